// ===== pkg/nsc_map.vh
// Constants of the flash sequencing host: register map, fields, commands, timing.
// Assumes a 200 MHz system clock and a byte-wide multiplexed flash port.
`ifndef NSC_MAP_VH
`define NSC_MAP_VH

// ----------------------------------------------------------------------------
// Software register offsets.
// ----------------------------------------------------------------------------
`define NSC_OFF_CTRL 8'h00
`define NSC_OFF_SRC 8'h04
`define NSC_OFF_DST 8'h08
`define NSC_OFF_STAT 8'h0C
`define NSC_OFF_ID 8'h10

// ----------------------------------------------------------------------------
// Control fields.
// ----------------------------------------------------------------------------
`define NSC_CTRL_OP_LSB 0
`define NSC_CTRL_OP_MSB 2
`define NSC_CTRL_NPL_LSB 4
`define NSC_CTRL_NPL_MSB 5
`define NSC_CTRL_USE71 8
`define NSC_CTRL_WP_N 9
`define NSC_OP_NONE 3'h0
`define NSC_OP_RESET 3'h1
`define NSC_OP_ID 3'h2
`define NSC_OP_STATUS 3'h3
`define NSC_OP_ERASE 3'h4
`define NSC_OP_COPY 3'h5
`define NSC_WP_N_RESET 1'h0
`define NSC_STATUS_RESET 8'hC0

// ----------------------------------------------------------------------------
// Flash commands.
// ----------------------------------------------------------------------------
`define NSC_CMD_READ 8'h00
`define NSC_CMD_READ_ALT 8'h03
`define NSC_CMD_PROG 8'h10
`define NSC_CMD_DUMMY 8'h11
`define NSC_CMD_ERASE_SETUP 8'h60
`define NSC_CMD_STATUS 8'h70
`define NSC_CMD_STATUS_MP 8'h71
`define NSC_CMD_COPY_IN 8'h8A
`define NSC_CMD_ID 8'h90
`define NSC_CMD_ERASE_GO 8'hD0
`define NSC_CMD_RESET 8'hFF

// ----------------------------------------------------------------------------
// Row address bits that select the plane, and the bit that must also match.
// ----------------------------------------------------------------------------
`define NSC_ROW_A14 5
`define NSC_ROW_A15 6
`define NSC_ROW_A26 17

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define NSC_CLK_MHZ 200
`define NSC_DIV_CYC 4'h4
`define NSC_T_PWR_US 10
`define NSC_PWR_CYC (`NSC_T_PWR_US * `NSC_CLK_MHZ)
`define NSC_T_WB_NS 100
`define NSC_WB_CYC ((`NSC_T_WB_NS * `NSC_CLK_MHZ + 999) / 1000)

`endif

// ===== test/nsc_flash_model.sv
// Behavioural flash device on the far side of the host sequencer.
// Assumes the bench resolves the shared data bus; ready/busy is driven high and low by the model itself.
`timescale 1ns/100ps
module nsc_flash_model #(
  parameter logic [31:0] ID_WORD = 32'hC0115A3C // Maker and device bytes are arbitrary.
) (
  // Strobes.
  input logic ce_n_i,
  input logic cle_i,
  input logic ale_i,
  input logic we_n_i,
  input logic re_n_i,
  input logic wp_n_i,
  // Data, fault choice, ready and command history.
  input logic [7:0] io_i,
  input logic [3:0] fail_i,
  output logic [7:0] io_o,
  output logic rb_n_o,
  output logic [63:0] hist_o
);
  logic [1:0] mode = 2'h0;
  logic mp = 1'h0;
  logic [3:0] fl = 4'h0;
  logic [2:0] na = 3'h0;
  logic [1:0] idx = 2'h0;
  logic [7:0] dout = 8'h0;
  time t_end = 0;
  wire [7:0] stat = {wp_n_i, rb_n_o, 1'h0, mp ? fl : 4'h0, |fl};
  initial begin
    rb_n_o = 1'h1;
    hist_o = 64'h0;
    #0.3;
    forever #1 rb_n_o = $time >= t_end;
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      na = 3'h0;
      if (io_i == 8'hFF && hist_o[7:0] != 8'hFF) begin
        t_end = $time + 500;
        fl = 4'h0;
      end
      if (io_i inside {8'hD0, 8'h10}) begin
        t_end = $time + 1000;
        fl = fail_i;
      end
      if (io_i == 8'h11) t_end = $time + 40;
      mode = (io_i inside {8'h70, 8'h71}) ? 2'h1 : (io_i == 8'h90) ? 2'h2 : 2'h0;
      if (mode == 2'h1) mp = io_i[0];
      idx = 2'h0;
      hist_o = {hist_o[55:0], io_i};
    end else if (!ce_n_i && ale_i) begin
      na = na + 3'h1;
      if (na == 3'h4 && hist_o[7:0] inside {8'h00, 8'h03}) t_end = $time + 300;
    end
  end
  always @(negedge re_n_i) begin
    dout = mode == 2'h2 ? ID_WORD[8*idx+:8] : stat;
    idx = idx + 2'h1;
  end
  assign io_o = (ce_n_i || re_n_i) ? ~dout : (mode == 2'h1 ? stat : dout);
endmodule

// ===== test/nsc_host_ctrl_chk.sv
// Assertions on the flash pins of the host sequencer.
// Assumes binding into the top module and the shared constants header.
`timescale 1ns/100ps
`include "nsc_map.vh"
module nsc_host_ctrl_chk (
  input logic sys_clk_i,
  input logic rst_n_i,
  input logic chip_enable_n_o,
  input logic cmd_latch_o,
  input logic addr_latch_o,
  input logic write_strobe_n_o,
  input logic read_strobe_n_o,
  input logic write_protect_n_o,
  input logic ready_busy_n_i,
  input logic [7:0] flash_io_o,
  input logic flash_io_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [11:0] up_cnt;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) up_cnt <= 12'h0;
    else if (up_cnt < `NSC_PWR_CYC) up_cnt <= up_cnt + 12'h1;
  end
  pwr_lock_a: assert property (up_cnt < `NSC_PWR_CYC
    |-> chip_enable_n_o && !write_protect_n_o) else $error("flash touched during power-up");
  latch_excl_a: assert property (!(cmd_latch_o && addr_latch_o))
    else $error("both latches high");
  strobe_ce_a: assert property (!(write_strobe_n_o && read_strobe_n_o)
    |-> !chip_enable_n_o) else $error("strobe without chip enable");
  read_float_a: assert property (!read_strobe_n_o |-> flash_io_oe_n_o)
    else $error("host drives bus during read");
  busy_cmd_a: assert property ($fell(write_strobe_n_o) && cmd_latch_o
    && !ready_busy_n_i |-> flash_io_o inside {8'h70, 8'h71, 8'hFF})
    else $error("command while busy");
  cmd_legal_a: assert property ($fell(write_strobe_n_o) && cmd_latch_o
    |-> flash_io_o inside {8'h00, 8'h03, 8'h10, 8'h11, 8'h60, 8'h70, 8'h71, 8'h8A, 8'h90,
    8'hD0, 8'hFF}) else $error("illegal flash command");
  we_low_a: assert property ($fell(write_strobe_n_o) |-> ##[1:5] write_strobe_n_o)
    else $error("write strobe stuck low");
  re_low_a: assert property ($fell(read_strobe_n_o) |-> ##[1:5] read_strobe_n_o)
    else $error("read strobe stuck low");
  we_gap_a: assert property ($rose(write_strobe_n_o) |-> write_strobe_n_o[*3])
    else $error("write strobe gap short");
  io_hold_a: assert property (!write_strobe_n_o && !$past(write_strobe_n_o)
    |-> $stable(flash_io_o) && !flash_io_oe_n_o) else $error("data moved in strobe");
endmodule
bind nsc_host_ctrl nsc_host_ctrl_chk nsc_host_ctrl_chk_inst (.sys_clk_i, .rst_n_i,
  .chip_enable_n_o, .cmd_latch_o, .addr_latch_o, .write_strobe_n_o, .read_strobe_n_o,
  .write_protect_n_o, .ready_busy_n_i, .flash_io_o, .flash_io_oe_n_o);

// ===== test/nsc_host_ctrl_tb.sv
// Self-checking bench for the flash host sequencer.
// Assumes the behavioural flash model on the far side.
`timescale 1ns/100ps
`include "nsc_map.vh"
module nsc_host_ctrl_tb;
  localparam logic [31:0] ID_WORD = 32'hC0115A3C; // Arbitrary identity bytes.
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] sw_addr = 8'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'h0;
  logic sw_rd = 1'h0;
  logic [3:0] fail = 4'h0;
  logic [31:0] sw_rdata, d;
  logic ce_n, cle, ale, we_n, re_n, wp_n, rb_n, oe_n;
  logic [7:0] f_out, m_io;
  logic [63:0] hist;
  int n_fail = 0;
  int samples_checked = 0;
  wire [7:0] io_bus = oe_n ? m_io : f_out;
  always #2.5 sys_clk = ~sys_clk;
  nsc_host_ctrl nsc_host_ctrl_inst (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sw_addr_i(sw_addr),
    .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
    .chip_enable_n_o(ce_n), .cmd_latch_o(cle), .addr_latch_o(ale), .write_strobe_n_o(we_n),
    .read_strobe_n_o(re_n), .write_protect_n_o(wp_n), .ready_busy_n_i(rb_n),
    .flash_io_i(io_bus), .flash_io_o(f_out), .flash_io_oe_n_o(oe_n));
  nsc_flash_model #(.ID_WORD(ID_WORD)) nsc_flash_model_inst (.ce_n_i(ce_n), .cle_i(cle),
    .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .wp_n_i(wp_n), .io_i(io_bus), .fail_i(fail),
    .io_o(m_io), .rb_n_o(rb_n), .hist_o(hist));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'h1;
    @(posedge sys_clk);
    sw_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge sys_clk);
    sw_rd <= 1'h0;
    #1 d = sw_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_stat(input int b, input logic v);
    for (int i = 0; i < 3000; i++) begin
      rd(`NSC_OFF_STAT);
      if (d[b] === v) return;
    end
    chk("wait", 1'h0, 1'h1);
    end_sim;
  endtask
  task automatic run_op(input logic [31:0] v);
    wr(`NSC_OFF_CTRL, v);
    wait_stat(0, 1'h0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(8'h14);
    chk("unmapped", d, 32'h0);
    wr(`NSC_OFF_CTRL, 32'h202);
    chk("pwr lock", {ce_n, wp_n}, 2'h2);
    wait_stat(2, 1'h1);
    run_op(32'h201);
    run_op(32'h203);
    chk("after reset", d[15:8], 8'hC0);
    chk("reset seq", hist[15:0], 16'hFF70);
    run_op(32'h202);
    rd(`NSC_OFF_ID);
    chk("id", d, ID_WORD);
    $display("reset and id done");
    fail <= 4'h5;
    run_op(32'h334);
    chk("mp erase", d[20:8], {1'h1, 4'h5, 8'hCB});
    chk("mp erase seq", hist[47:0], 48'h60606060D071);
    fail <= 4'h1;
    run_op(32'h204);
    chk("erase", d[20:8], {1'h1, 4'h0, 8'hC1});
    chk("erase seq", hist[15:0], 16'hD070);
    $display("erase done");
    fail <= 4'h0;
    wr(`NSC_OFF_SRC, 32'h60);
    wr(`NSC_OFF_DST, 32'h460);
    run_op(32'h315);
    chk("copy rd seq", hist[55:40], 16'h0003);
    chk("copy wr seq", hist[39:8], 32'h8A118A10);
    chk("copy pass", d[20], 1'h0);
    wr(`NSC_OFF_DST, 32'h20060);
    wr(`NSC_OFF_CTRL, 32'h315);
    rd(`NSC_OFF_STAT);
    chk("copy refused", d[1:0], 2'h2);
    $display("copy done");
    wr(`NSC_OFF_CTRL, 32'h334);
    wr(`NSC_OFF_CTRL, 32'h202);
    rd(`NSC_OFF_STAT);
    chk("busy refused", d[1:0], 2'h3);
    for (int i = 0; i < 400 && rb_n; i++) @(posedge sys_clk);
    chk("busy seen", rb_n, 1'h0);
    run_op(32'h201);
    chk("abort", hist[15:0], 16'hD0FF);
    $display("abort done");
    end_sim;
  end
endmodule

// ===== verilog/nsc_bus_cycle.v
// One byte cycle on the flash port: command, address or data read.
// Assumes the caller holds chip enable low and issues go only when ready.
`timescale 1ns/100ps
`include "nsc_map.vh"

module nsc_bus_cycle (
  // Clock, reset and pacing.
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire tick_i,
  // Request.
  input wire go_i,
  input wire [1:0] kind_i,
  input wire [7:0] byte_i,
  output wire ready_o,
  output reg done_o,
  output reg [7:0] rbyte_o,
  // Flash pins.
  output reg cle_o,
  output reg ale_o,
  output reg we_n_o,
  output reg re_n_o,
  input wire [7:0] io_i,
  output reg [7:0] io_o,
  output reg io_oe_n_o
);

  localparam C_IDLE = 3'b001;
  localparam C_LOW = 3'b010;
  localparam C_HIGH = 3'b100;
  localparam K_CMD = 2'h0;
  localparam K_ADDR = 2'h1;

  reg [2:0] state_reg;
  reg read_reg;

  assign ready_o = state_reg[0];

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= C_IDLE;
      read_reg <= 1'b0;
      done_o <= 1'b0;
      rbyte_o <= 8'h00;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      re_n_o <= 1'b1;
      io_o <= 8'h00;
      io_oe_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        C_IDLE: begin
          if (go_i) begin
            read_reg <= !(kind_i == K_CMD || kind_i == K_ADDR);
            cle_o <= (kind_i == K_CMD);
            ale_o <= (kind_i == K_ADDR);
            io_o <= byte_i;
            io_oe_n_o <= !(kind_i == K_CMD || kind_i == K_ADDR);
            we_n_o <= !(kind_i == K_CMD || kind_i == K_ADDR);
            re_n_o <= (kind_i == K_CMD || kind_i == K_ADDR);
            state_reg <= C_LOW;
          end
        end
        C_LOW: begin
          if (tick_i) begin
            if (read_reg) begin
              rbyte_o <= io_i;
            end
            we_n_o <= 1'b1;
            re_n_o <= 1'b1;
            state_reg <= C_HIGH;
          end
        end
        C_HIGH: begin
          if (tick_i) begin
            cle_o <= 1'b0;
            ale_o <= 1'b0;
            io_oe_n_o <= 1'b1;
            done_o <= 1'b1;
            state_reg <= C_IDLE;
          end
        end
        default: begin
          state_reg <= C_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== verilog/nsc_host_ctrl.v
// Host sequencer for a multi-plane NAND flash: erase, copy-back, status, ID, reset.
// Assumes a software master on a plain strobe port and the flash wired to the pins.
//
// Function
// - Multi-plane erase sends setup plus three address cycles per plane, four at most.
// - After ready, send 8Ah with destination address; 10h starts programming.
// - Source and destination must agree in A14, A15 and A26, else refused.
// - No partial page programming of copied pages before their block is erased.
// - Copy-back failures show in pass/fail; two-bit correction is advised.
// - Multi-plane copy-back: first source read 00h, later ones 03h, four planes.
// - Last plane is closed with 10h, never 11h.
// - Spare and second-half pointer commands never appear in a copy-back sequence.
// - Status mode persists; every read sequence restarts with its own read command.
// - Multi-plane program or erase is checked with 71h, pass/fail only when ready.
// - Wait 10 us after power-up; write protect held low until then.
// - While busy only status or reset commands may be issued.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "nsc_map.vh"

module nsc_host_ctrl (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_n_i,
  // Software register port.
  input wire [7:0] sw_addr_i,
  input wire [31:0] sw_wdata_i,
  input wire sw_wr_i,
  input wire sw_rd_i,
  output reg [31:0] sw_rdata_o,
  // Flash control pins.
  output reg chip_enable_n_o,
  output wire cmd_latch_o,
  output wire addr_latch_o,
  output wire write_strobe_n_o,
  output wire read_strobe_n_o,
  output reg write_protect_n_o,
  input wire ready_busy_n_i,
  // Flash data pins.
  input wire [7:0] flash_io_i,
  output wire [7:0] flash_io_o,
  output wire flash_io_oe_n_o
);

  // --------------------------------------------------------------------------
  // State codes.
  // --------------------------------------------------------------------------
  localparam S_PWR = 8'b00000001;
  localparam S_IDLE = 8'b00000010;
  localparam S_CMD1 = 8'b00000100;
  localparam S_ADR = 8'b00001000;
  localparam S_CMD2 = 8'b00010000;
  localparam S_WAIT = 8'b00100000;
  localparam S_STC = 8'b01000000;
  localparam S_RD = 8'b10000000;
  localparam K_CMD = 2'h0;
  localparam K_ADDR = 2'h1;
  localparam K_READ = 2'h2;

  reg [7:0] state_reg;
  reg [2:0] op_reg;
  reg [1:0] nplane_reg;
  reg [1:0] plane_reg;
  reg [1:0] bcnt_reg;
  reg prog_reg;
  reg inflight_reg;
  reg abort_reg;
  reg refused_reg;
  reg use71_reg;
  reg st71_reg;
  reg [11:0] wait_cnt_reg;
  reg [17:0] src_reg;
  reg [17:0] dst_reg;
  reg [7:0] stat_reg;
  reg [31:0] id_reg;
  reg [31:0] rdata_next;
  reg [7:0] byte_next;
  reg [1:0] kind_next;
  reg [1:0] nbytes_next;
  wire tick;
  wire eng_ready;
  wire eng_done;
  wire [7:0] eng_rbyte;
  wire go;
  wire start;
  wire [2:0] start_op;
  wire mismatch;
  wire last_plane;
  wire [31:0] wait_cnt_ext;

  // --------------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------------
  function [17:0] plane_row;
    input [17:0] row;
    input [1:0] p;
    begin
      plane_row = row;
      plane_row[`NSC_ROW_A14] = p[0];
      plane_row[`NSC_ROW_A15] = p[1];
    end
  endfunction

  function [7:0] addr_byte;
    input [17:0] row;
    input [1:0] sel;
    begin
      if (sel == 2'h0) begin
        addr_byte = 8'h00;
      end else if (sel == 2'h1) begin
        addr_byte = row[7:0];
      end else if (sel == 2'h2) begin
        addr_byte = row[15:8];
      end else begin
        addr_byte = {6'h00, row[17:16]};
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Sub-blocks.
  // --------------------------------------------------------------------------
  nsc_tick u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  nsc_bus_cycle u_cycle (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick),
    .go_i(go),
    .kind_i(kind_next),
    .byte_i(byte_next),
    .ready_o(eng_ready),
    .done_o(eng_done),
    .rbyte_o(eng_rbyte),
    .cle_o(cmd_latch_o),
    .ale_o(addr_latch_o),
    .we_n_o(write_strobe_n_o),
    .re_n_o(read_strobe_n_o),
    .io_i(flash_io_i),
    .io_o(flash_io_o),
    .io_oe_n_o(flash_io_oe_n_o)
  );

  // --------------------------------------------------------------------------
  // Byte selection for the current step.
  // --------------------------------------------------------------------------
  assign start_op = sw_wdata_i[`NSC_CTRL_OP_MSB:`NSC_CTRL_OP_LSB];
  assign start = sw_wr_i && (sw_addr_i == `NSC_OFF_CTRL) && (start_op != `NSC_OP_NONE);
  assign mismatch = (src_reg[`NSC_ROW_A14] != dst_reg[`NSC_ROW_A14]) ||
    (src_reg[`NSC_ROW_A15] != dst_reg[`NSC_ROW_A15]) ||
    (src_reg[`NSC_ROW_A26] != dst_reg[`NSC_ROW_A26]);
  assign last_plane = (plane_reg == nplane_reg);
  assign wait_cnt_ext = {20'h00000, wait_cnt_reg};
  assign go = (state_reg[2] || state_reg[3] || state_reg[4] || state_reg[6] || state_reg[7]) &&
    eng_ready && !inflight_reg && !abort_reg;

  always @* begin
    kind_next = K_CMD;
    byte_next = 8'h00;
    nbytes_next = 2'h3;
    if (op_reg == `NSC_OP_ID) begin
      nbytes_next = 2'h0;
    end else if (op_reg == `NSC_OP_ERASE) begin
      nbytes_next = 2'h2;
    end
    case (state_reg)
      S_CMD1: begin
        if (op_reg == `NSC_OP_RESET) begin
          byte_next = `NSC_CMD_RESET;
        end else if (op_reg == `NSC_OP_ID) begin
          byte_next = `NSC_CMD_ID;
        end else if (op_reg == `NSC_OP_ERASE) begin
          byte_next = `NSC_CMD_ERASE_SETUP;
        end else if (prog_reg) begin
          byte_next = `NSC_CMD_COPY_IN;
        end else if (plane_reg == 2'h0) begin
          byte_next = `NSC_CMD_READ;
        end else begin
          byte_next = `NSC_CMD_READ_ALT;
        end
      end
      S_ADR: begin
        kind_next = K_ADDR;
        if (op_reg == `NSC_OP_ERASE) begin
          byte_next = addr_byte(plane_row(src_reg, plane_reg), bcnt_reg + 2'h1);
        end else if (op_reg == `NSC_OP_COPY && prog_reg) begin
          byte_next = addr_byte(plane_row(dst_reg, plane_reg), bcnt_reg);
        end else if (op_reg == `NSC_OP_COPY) begin
          byte_next = addr_byte(plane_row(src_reg, plane_reg), bcnt_reg);
        end
      end
      S_CMD2: begin
        if (op_reg == `NSC_OP_ERASE) begin
          byte_next = `NSC_CMD_ERASE_GO;
        end else if (last_plane) begin
          byte_next = `NSC_CMD_PROG;
        end else begin
          byte_next = `NSC_CMD_DUMMY;
        end
      end
      S_STC: begin
        byte_next = st71_reg ? `NSC_CMD_STATUS_MP : `NSC_CMD_STATUS;
      end
      S_RD: begin
        kind_next = K_READ;
      end
      default: begin
        kind_next = K_CMD;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer.
  // --------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= S_PWR;
      op_reg <= `NSC_OP_NONE;
      nplane_reg <= 2'h0;
      plane_reg <= 2'h0;
      bcnt_reg <= 2'h0;
      prog_reg <= 1'b0;
      inflight_reg <= 1'b0;
      abort_reg <= 1'b0;
      refused_reg <= 1'b0;
      use71_reg <= 1'b0;
      st71_reg <= 1'b0;
      wait_cnt_reg <= 12'h000;
      src_reg <= 18'h00000;
      dst_reg <= 18'h00000;
      stat_reg <= `NSC_STATUS_RESET;
      id_reg <= 32'h00000000;
      chip_enable_n_o <= 1'b1;
      write_protect_n_o <= `NSC_WP_N_RESET;
    end else begin
      if (go) begin
        inflight_reg <= 1'b1;
      end else if (eng_done) begin
        inflight_reg <= 1'b0;
      end
      if (sw_wr_i && sw_addr_i == `NSC_OFF_SRC) begin
        src_reg <= sw_wdata_i[17:0];
      end
      if (sw_wr_i && sw_addr_i == `NSC_OFF_DST) begin
        dst_reg <= sw_wdata_i[17:0];
      end
      if (sw_wr_i && sw_addr_i == `NSC_OFF_CTRL && !state_reg[0]) begin
        write_protect_n_o <= sw_wdata_i[`NSC_CTRL_WP_N];
        use71_reg <= sw_wdata_i[`NSC_CTRL_USE71];
      end
      if (start && !state_reg[1] && start_op != `NSC_OP_RESET) begin
        refused_reg <= 1'b1;
      end else if (start && state_reg[1] && start_op == `NSC_OP_COPY && mismatch) begin
        refused_reg <= 1'b1;
      end else if (sw_rd_i && sw_addr_i == `NSC_OFF_STAT) begin
        refused_reg <= 1'b0;
      end
      if (start && start_op == `NSC_OP_RESET && !state_reg[0] && !state_reg[1]) begin
        abort_reg <= 1'b1;
      end
      chip_enable_n_o <= state_reg[0] || state_reg[1];
      if (abort_reg && !inflight_reg && !state_reg[0] && !state_reg[1]) begin
        abort_reg <= 1'b0;
        op_reg <= `NSC_OP_RESET;
        state_reg <= S_CMD1;
      end else begin
        case (state_reg)
          S_PWR: begin
            wait_cnt_reg <= wait_cnt_reg + 12'h001;
            if (wait_cnt_ext == `NSC_PWR_CYC - 1) begin
              state_reg <= S_IDLE;
            end
          end
          S_IDLE: begin
            if (start && !(start_op == `NSC_OP_COPY && mismatch)) begin
              op_reg <= start_op;
              nplane_reg <= sw_wdata_i[`NSC_CTRL_NPL_MSB:`NSC_CTRL_NPL_LSB];
              st71_reg <= (start_op == `NSC_OP_STATUS) ? sw_wdata_i[`NSC_CTRL_USE71] :
                (sw_wdata_i[`NSC_CTRL_NPL_MSB:`NSC_CTRL_NPL_LSB] != 2'h0);
              plane_reg <= 2'h0;
              prog_reg <= 1'b0;
              bcnt_reg <= 2'h0;
              state_reg <= (start_op == `NSC_OP_STATUS) ? S_STC : S_CMD1;
            end
          end
          S_CMD1: begin
            if (eng_done) begin
              bcnt_reg <= 2'h0;
              wait_cnt_reg <= 12'h000;
              state_reg <= (op_reg == `NSC_OP_RESET) ? S_WAIT : S_ADR;
            end
          end
          S_ADR: begin
            if (eng_done && bcnt_reg != nbytes_next) begin
              bcnt_reg <= bcnt_reg + 2'h1;
            end else if (eng_done) begin
              bcnt_reg <= 2'h0;
              wait_cnt_reg <= 12'h000;
              if (op_reg == `NSC_OP_ID) begin
                state_reg <= S_RD;
              end else if (op_reg == `NSC_OP_ERASE && !last_plane) begin
                plane_reg <= plane_reg + 2'h1;
                state_reg <= S_CMD1;
              end else if (op_reg == `NSC_OP_ERASE || prog_reg) begin
                state_reg <= S_CMD2;
              end else begin
                state_reg <= S_WAIT;
              end
            end
          end
          S_CMD2: begin
            if (eng_done) begin
              wait_cnt_reg <= 12'h000;
              state_reg <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (wait_cnt_ext != `NSC_WB_CYC) begin
              wait_cnt_reg <= wait_cnt_reg + 12'h001;
            end else if (ready_busy_n_i) begin
              if (op_reg == `NSC_OP_RESET) begin
                state_reg <= S_IDLE;
              end else if (op_reg == `NSC_OP_ERASE || (prog_reg && last_plane)) begin
                state_reg <= S_STC;
              end else if (last_plane) begin
                prog_reg <= 1'b1;
                plane_reg <= 2'h0;
                state_reg <= S_CMD1;
              end else begin
                plane_reg <= plane_reg + 2'h1;
                state_reg <= S_CMD1;
              end
            end
          end
          S_STC: begin
            if (eng_done) begin
              bcnt_reg <= 2'h0;
              state_reg <= S_RD;
            end
          end
          S_RD: begin
            if (eng_done && op_reg == `NSC_OP_ID) begin
              id_reg <= {eng_rbyte, id_reg[31:8]};
              bcnt_reg <= bcnt_reg + 2'h1;
              if (bcnt_reg == 2'h3) begin
                state_reg <= S_IDLE;
              end
            end else if (eng_done) begin
              stat_reg <= eng_rbyte;
              state_reg <= S_IDLE;
            end
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software read port.
  // --------------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    if (sw_addr_i == `NSC_OFF_CTRL) begin
      rdata_next = {22'h000000, write_protect_n_o, use71_reg, 2'h0, nplane_reg, 1'b0, op_reg};
    end else if (sw_addr_i == `NSC_OFF_SRC) begin
      rdata_next = {14'h0000, src_reg};
    end else if (sw_addr_i == `NSC_OFF_DST) begin
      rdata_next = {14'h0000, dst_reg};
    end else if (sw_addr_i == `NSC_OFF_STAT) begin
      rdata_next[0] = !state_reg[1];
      rdata_next[1] = refused_reg;
      rdata_next[2] = !state_reg[0];
      rdata_next[15:8] = stat_reg;
      rdata_next[19:16] = st71_reg ? stat_reg[4:1] : 4'h0;
      rdata_next[20] = stat_reg[0];
    end else if (sw_addr_i == `NSC_OFF_ID) begin
      rdata_next = id_reg;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sw_rdata_o <= 32'h00000000;
    end else if (sw_rd_i) begin
      sw_rdata_o <= rdata_next;
    end else begin
      sw_rdata_o <= 32'h00000000;
    end
  end

endmodule

// ===== verilog/nsc_tick.v
// One-cycle enable divider that paces every flash strobe phase.
// Assumes a single free-running system clock.
`timescale 1ns/100ps
`include "nsc_map.vh"

module nsc_tick (
  // Clock and reset.
  input wire sys_clk_i,
  input wire rst_n_i,
  // Enable out.
  output reg tick_o
);

  reg [3:0] cnt_reg;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == `NSC_DIV_CYC - 4'h1) begin
      cnt_reg <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      tick_o <= 1'b0;
    end
  end

endmodule
